//--- core/afpl_top.sv
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "afpl_defs.svh"
module afpl_top #(
    parameter int PWRUP_CYC = `AFPL_PWRUP_CYC
) (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic power_req_i,
    input wire logic phase_low_i,
    input wire logic phase_present_i,
    input wire logic remote_lost_i,
    input wire logic remote_low_i,
    input wire logic reg_cmp_i,
    input wire logic overvolt_i,
    input wire logic undervolt_i,
    input wire logic load_dump_i,
    input wire logic rate_slow_i,
    input wire logic [7:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic gate_o,
    output logic lamp_o,
    output logic standby_o,
    output logic [1:0] sense_sel_o,
    output logic [11:0] ramp_o,
    output logic lrc_active_o,
    output logic [15:0] rdata_o
);
    logic rst_meta_r;
    logic rst_n;
    logic [`AFPL_NFLAG-1:0] flag_raw;
    logic [`AFPL_NFLAG-1:0] flag_meta_r;
    logic [`AFPL_NFLAG-1:0] flag_r;
    afpl_pkg::afpl_top_st_type st;
    afpl_pkg::afpl_top_st_type nxt;
    logic run;
    logic period_tick;
    logic lrc_on;
    logic [7:0] ud_count;
    logic [7:0] duty_pos;
    logic [7:0] cap;
    logic dig_end;
    logic cap_end;
    logic ana_end;
    logic fault;

    // reset is released through two flops so every flop leaves reset on one edge
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    assign flag_raw = {rate_slow_i, load_dump_i, undervolt_i, overvolt_i, reg_cmp_i,
                       remote_low_i, remote_lost_i, phase_present_i, phase_low_i, power_req_i};

    // comparator outputs are analog and asynchronous to the oscillator
    for (genvar gi = 0; gi < `AFPL_NFLAG; gi++)
    begin : g_sync
        always_ff @(posedge clock_i or negedge rst_n)
        begin
            if (!rst_n)
            begin
                flag_meta_r[gi] <= 1'b0;
                flag_r[gi] <= 1'b0;
            end
            else
            begin
                flag_meta_r[gi] <= flag_raw[gi];
                flag_r[gi] <= flag_meta_r[gi];
            end
        end
    end

    assign run = (st.pwr == afpl_pkg::PWR_RUN);
    assign period_tick = run && (st.pres == `AFPL_PRES_LAST);
    // lrc runs at low rpm and also whenever no phase is present
    assign lrc_on = flag_r[`AFPL_F_PHLOW] || !flag_r[`AFPL_F_PHOK];
    assign duty_pos = st.pres[11:4];

    always_comb
    begin
        if (flag_r[`AFPL_F_OV])
        begin
            cap = `AFPL_OV_CAP;
        end
        else if (!flag_r[`AFPL_F_PHOK])
        begin
            cap = `AFPL_UD_MIN;
        end
        else
        begin
            cap = `AFPL_UD_MAX;
        end
    end

    // full count means no digital end, so lrc can still reach 100% duty
    assign dig_end = lrc_on && (duty_pos == ud_count) && (ud_count != `AFPL_UD_MAX);
    assign cap_end = (cap != `AFPL_UD_MAX) && (duty_pos >= cap);
    // undervoltage pushes the analog side to full duty
    // the synced comparator still shows the last period's ramp for two cycles, so blank it
    assign ana_end = flag_r[`AFPL_F_CMP] && !flag_r[`AFPL_F_UV] && (st.pres >= `AFPL_CMP_BLANK);
    assign fault = flag_r[`AFPL_F_OV] || !flag_r[`AFPL_F_PHOK]
                   || (flag_r[`AFPL_F_UV] && !flag_r[`AFPL_F_PHLOW]);

    always_comb
    begin
        nxt = st;
        nxt.rdata = 16'h0000;
        case (st.pwr)
            afpl_pkg::PWR_OFF:
            begin
                nxt.dly = 16'h0000;
                if (flag_r[`AFPL_F_PWR])
                begin
                    nxt.pwr = afpl_pkg::PWR_DELAY;
                end
            end
            afpl_pkg::PWR_DELAY:
            begin
                // any dropout restarts the wait
                if (!flag_r[`AFPL_F_PWR])
                begin
                    nxt.pwr = afpl_pkg::PWR_OFF;
                end
                else if (st.dly == 16'(PWRUP_CYC - 1))
                begin
                    nxt.pwr = afpl_pkg::PWR_RUN;
                end
                else
                begin
                    nxt.dly = st.dly + 16'h0001;
                end
            end
            afpl_pkg::PWR_RUN:
            begin
                if (!flag_r[`AFPL_F_PWR])
                begin
                    nxt.pwr = afpl_pkg::PWR_OFF;
                end
            end
            default:
            begin
                nxt.pwr = afpl_pkg::PWR_OFF;
            end
        endcase
        nxt.standby = (nxt.pwr != afpl_pkg::PWR_RUN);
        // leaving run drops gate and lamp on the same edge that raises standby
        if (!run || nxt.standby)
        begin
            nxt.pres = 12'h000;
            nxt.gate = 1'b0;
            nxt.ana_end = 1'b0;
            nxt.want_up = 1'b1;
            nxt.lamp = 1'b0;
        end
        else
        begin
            nxt.pres = st.pres + 12'h001;
            if (period_tick)
            begin
                // a trip in the last cycle still counts against this period
                nxt.want_up = !(st.ana_end || (ana_end && st.gate));
                nxt.ana_end = 1'b0;
            end
            else if (ana_end && st.gate)
            begin
                nxt.ana_end = 1'b1;
            end
            if (flag_r[`AFPL_F_LD])
            begin
                nxt.gate = 1'b0;
            end
            else if (period_tick)
            begin
                nxt.gate = 1'b1;
            end
            else if (ana_end || st.ana_end || dig_end || cap_end)
            begin
                nxt.gate = 1'b0;
            end
            nxt.lamp = (fault || st.lamp_test) && !flag_r[`AFPL_F_LD];
        end
        nxt.ramp = ~nxt.pres;
        nxt.lrc = lrc_on && run;
        if (flag_r[`AFPL_F_RLOST])
        begin
            nxt.sense = afpl_pkg::SENSE_LOCAL_FULL;
        end
        else if (flag_r[`AFPL_F_RLOW])
        begin
            nxt.sense = afpl_pkg::SENSE_LOCAL_ATTN;
        end
        else
        begin
            nxt.sense = afpl_pkg::SENSE_REMOTE;
        end
        if (wr_i && addr_i == `AFPL_REG_CTRL)
        begin
            nxt.lamp_test = wdata_i[`AFPL_CTRL_LAMP_TEST];
        end
        if (rd_i)
        begin
            case (addr_i)
                `AFPL_REG_CTRL:
                begin
                    nxt.rdata = {15'h0000, st.lamp_test};
                end
                `AFPL_REG_STATUS:
                begin
                    nxt.rdata = {3'h0, flag_r, st.lrc, st.gate, st.standby};
                end
                `AFPL_REG_COUNT:
                begin
                    nxt.rdata = {8'h00, ud_count};
                end
                default:
                begin
                    nxt.rdata = 16'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= '{pwr: afpl_pkg::PWR_OFF, dly: 16'h0000, pres: 12'h000, ramp: 12'hfff,
                    gate: 1'b0, lamp: 1'b0, standby: 1'b1, lrc: 1'b0,
                    sense: afpl_pkg::SENSE_REMOTE, ana_end: 1'b0, want_up: 1'b1,
                    lamp_test: `AFPL_RST_LAMP_TEST, rdata: 16'h0000};
        end
        else
        begin
            st <= nxt;
        end
    end

    afpl_lrc_counter u_lrc (
        .clock_i(clock_i),
        .rst_n_i(rst_n),
        .run_i(run),
        .period_tick_i(period_tick),
        .rate_slow_i(flag_r[`AFPL_F_SLOW]),
        .want_up_i(st.want_up),
        .active_i(lrc_on),
        .count_o(ud_count)
    );

    assign gate_o = st.gate;
    assign lamp_o = st.lamp;
    assign standby_o = st.standby;
    assign sense_sel_o = st.sense;
    assign ramp_o = st.ramp;
    assign lrc_active_o = st.lrc;
    assign rdata_o = st.rdata;

    // cycles since the last period tick; all ones outside run and until a first tick is seen
    logic [12:0] tick_gap_r;
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_gap_r <= 13'h1fff;
        end
        else if (period_tick)
        begin
            tick_gap_r <= 13'h0000;
        end
        else if (!run)
        begin
            tick_gap_r <= 13'h1fff;
        end
        else if (tick_gap_r != 13'h1fff)
        begin
            tick_gap_r <= tick_gap_r + 13'h0001;
        end
    end

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n);

    standby_gate_off_a: assert property (st.standby |-> !st.gate && !st.lamp)
        else $error("gate or lamp active in standby");
    load_dump_off_a: assert property (run && flag_r[`AFPL_F_LD] |=> !st.gate && !st.lamp)
        else $error("load dump did not force outputs off");
    period_start_a: assert property (period_tick && flag_r[`AFPL_F_PWR] && !flag_r[`AFPL_F_LD]
                                     |=> st.gate && st.pres == 12'h000)
        else $error("period did not start with gate on");
    comparator_hold_a: assert property (st.ana_end && !period_tick |=> !st.gate)
        else $error("gate on after comparator end");
    prescale_wrap_a: assert property (period_tick && tick_gap_r != 13'h1fff
                                      |-> tick_gap_r == {1'b0, `AFPL_PRES_LAST})
        else $error("pwm period is not 4096 clocks");
    fault_lamp_a: assert property (run && flag_r[`AFPL_F_PWR] && flag_r[`AFPL_F_OV] && !flag_r[`AFPL_F_LD]
                                   |=> st.lamp)
        else $error("overvoltage did not light lamp");
    sense_lost_a: assert property (flag_r[`AFPL_F_RLOST] |=> st.sense == afpl_pkg::SENSE_LOCAL_FULL)
        else $error("sense loss did not select local input");
    sense_attn_a: assert property (!flag_r[`AFPL_F_RLOST] && flag_r[`AFPL_F_RLOW]
                                   |=> st.sense == afpl_pkg::SENSE_LOCAL_ATTN)
        else $error("low remote sense did not select attenuated local");
    pwrup_delay_a: assert property (st.pwr == afpl_pkg::PWR_OFF |=> st.pwr != afpl_pkg::PWR_RUN)
        else $error("power-up skipped the delay");
    digital_end_a: assert property (run && dig_end && !period_tick |=> !st.gate)
        else $error("gate on after digital end");

    gate_on_c: cover property ($rose(st.gate));
    comparator_end_c: cover property (st.gate ##1 st.ana_end && !st.gate);
    load_dump_c: cover property (run && flag_r[`AFPL_F_LD]);
endmodule : afpl_top

//--- core/afpl_defs.svh
`ifndef AFPL_DEFS_SVH
`define AFPL_DEFS_SVH
`define AFPL_CLK_NS 40
`define AFPL_PWRUP_DLY_NS 1000000
`define AFPL_PWRUP_CYC ((`AFPL_PWRUP_DLY_NS + `AFPL_CLK_NS - 1) / `AFPL_CLK_NS)
`define AFPL_PRES_LAST 12'hfff
`define AFPL_DIV_FAST_LAST 6'h0b
`define AFPL_DIV_SLOW_LAST 6'h2f
`define AFPL_UD_MIN 8'h4a
`define AFPL_UD_MAX 8'hff
`define AFPL_OV_CAP 8'h0c
`define AFPL_CMP_BLANK 12'h002
`define AFPL_REG_CTRL 8'h00
`define AFPL_REG_STATUS 8'h04
`define AFPL_REG_COUNT 8'h08
`define AFPL_CTRL_LAMP_TEST 0
`define AFPL_RST_LAMP_TEST 1'h0
`define AFPL_NFLAG 10
`define AFPL_F_PWR 0
`define AFPL_F_PHLOW 1
`define AFPL_F_PHOK 2
`define AFPL_F_RLOST 3
`define AFPL_F_RLOW 4
`define AFPL_F_CMP 5
`define AFPL_F_OV 6
`define AFPL_F_UV 7
`define AFPL_F_LD 8
`define AFPL_F_SLOW 9
`endif

//--- core/afpl_pkg.sv
package afpl_pkg;
    typedef enum logic [1:0] {
        PWR_OFF = 2'b00,
        PWR_DELAY = 2'b01,
        PWR_RUN = 2'b10
    } afpl_pwr_type;
    typedef enum logic [1:0] {
        SENSE_REMOTE = 2'b00,
        SENSE_LOCAL_FULL = 2'b01,
        SENSE_LOCAL_ATTN = 2'b10
    } afpl_sense_type;
    typedef struct packed {
        afpl_pwr_type pwr;
        logic [15:0] dly;
        logic [11:0] pres;
        logic [11:0] ramp;
        logic gate;
        logic lamp;
        logic standby;
        logic lrc;
        afpl_sense_type sense;
        logic ana_end;
        logic want_up;
        logic lamp_test;
        logic [15:0] rdata;
    } afpl_top_st_type;
    typedef struct packed {
        logic [5:0] div;
        logic slow;
        logic [2:0] hist;
        logic dir;
        logic [7:0] cnt;
    } afpl_lrc_st_type;
endpackage : afpl_pkg

//--- core/afpl_lrc_counter.sv
`timescale 1ns/1ps
`include "afpl_defs.svh"
module afpl_lrc_counter (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    input wire logic period_tick_i,
    input wire logic rate_slow_i,
    input wire logic want_up_i,
    input wire logic active_i,
    output logic [7:0] count_o
);
    afpl_pkg::afpl_lrc_st_type st;
    afpl_pkg::afpl_lrc_st_type nxt;
    logic [2:0] hist_nxt;
    logic [5:0] div_last;

    always_comb
    begin
        nxt = st;
        hist_nxt = {st.hist[1:0], want_up_i};
        div_last = st.slow ? `AFPL_DIV_SLOW_LAST : `AFPL_DIV_FAST_LAST;
        if (!run_i)
        begin
            // standby holds the chain at its preset: 29% duty, counting up
            nxt.div = 6'h00;
            nxt.slow = rate_slow_i;
            nxt.hist = 3'h7;
            nxt.dir = 1'b1;
            nxt.cnt = `AFPL_UD_MIN;
        end
        else if (period_tick_i)
        begin
            if (st.div == div_last)
            begin
                nxt.div = 6'h00;
                nxt.slow = rate_slow_i;
                nxt.hist = hist_nxt;
                if (hist_nxt == {3{~st.dir}})
                begin
                    nxt.dir = ~st.dir;
                end
                if (!active_i)
                begin
                    // lrc idle: park at full so handing back costs no sudden drop
                    nxt.cnt = `AFPL_UD_MAX;
                end
                else if (nxt.dir && st.cnt != `AFPL_UD_MAX)
                begin
                    nxt.cnt = st.cnt + 8'h01;
                end
                else if (!nxt.dir && st.cnt > `AFPL_UD_MIN)
                begin
                    nxt.cnt = st.cnt - 8'h01;
                end
            end
            else
            begin
                nxt.div = st.div + 6'h01;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st <= '{div: 6'h00, slow: 1'b0, hist: 3'h7, dir: 1'b1, cnt: `AFPL_UD_MIN};
        end
        else
        begin
            st <= nxt;
        end
    end

    assign count_o = st.cnt;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);

    count_floor_a: assert property (st.cnt >= `AFPL_UD_MIN)
        else $error("up/down count below floor");
    dir_up_agree_a: assert property ($rose(st.dir) |-> st.hist == 3'h7)
        else $error("direction rose without three agreeing samples");
    dir_down_agree_a: assert property ($fell(st.dir) |-> st.hist == 3'h0)
        else $error("direction fell without three agreeing samples");
    count_rise_c: cover property (run_i && active_i && st.cnt == `AFPL_UD_MIN ##1 st.cnt == `AFPL_UD_MIN + 8'h01);
endmodule : afpl_lrc_counter

//--- verif/afpl_field_model.sv
`timescale 1ns/1ps
// far side: regulator comparator watching the descending ramp against the filter level
module afpl_field_model (
    input wire logic clock_i,
    input wire logic gate_i,
    input wire logic [11:0] ramp_i,
    input wire logic [11:0] level_i,
    output logic reg_cmp_o,
    output logic [15:0] field_on_o
);
    // comparator trips once the ramp has fallen below the filter level; level 0 never trips
    assign reg_cmp_o = (ramp_i < level_i);
    // field current proxy: cycles the switch has been on, cleared each off cycle
    always_ff @(posedge clock_i)
    begin
        field_on_o <= gate_i ? field_on_o + 16'h0001 : 16'h0000;
    end
endmodule : afpl_field_model

//--- verif/alternator_field_pwm_lrc_test.sv
`timescale 1ns/1ps
module alternator_field_pwm_lrc_test;
    logic clock_i, arst_n_i, power_req_i, phase_low_i, phase_present_i, remote_lost_i, remote_low_i;
    logic reg_cmp, overvolt_i, undervolt_i, load_dump_i, rate_slow_i, wr_i, rd_i;
    logic [7:0] addr_i;
    logic [15:0] wdata_i, rdata_o, d;
    logic gate_o, lamp_o, standby_o, lrc_active_o, seen_on;
    logic [1:0] sense_sel_o;
    logic [11:0] ramp_o, level;
    int bad_count, comparisons, on_c, per_c, n;
    afpl_top #(.PWRUP_CYC(8)) afpl_top_i (.clock_i(clock_i), .arst_n_i(arst_n_i), .power_req_i(power_req_i),
        .phase_low_i(phase_low_i), .phase_present_i(phase_present_i), .remote_lost_i(remote_lost_i),
        .remote_low_i(remote_low_i), .reg_cmp_i(reg_cmp), .overvolt_i(overvolt_i), .undervolt_i(undervolt_i),
        .load_dump_i(load_dump_i), .rate_slow_i(rate_slow_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .gate_o(gate_o), .lamp_o(lamp_o), .standby_o(standby_o), .sense_sel_o(sense_sel_o),
        .ramp_o(ramp_o), .lrc_active_o(lrc_active_o), .rdata_o(rdata_o));
    afpl_field_model afpl_field_model_i (.clock_i(clock_i), .gate_i(gate_o), .ramp_i(ramp_o),
        .level_i(level), .reg_cmp_o(reg_cmp), .field_on_o());
    initial
    begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic print_verdict();
        if (bad_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    task automatic reg_write(input logic [7:0] a, input logic [15:0] v);
        @(posedge clock_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask : reg_write
    // read data stand only in the cycle after the strobe, so sample exactly there
    task automatic reg_read(input logic [7:0] a, output logic [15:0] v);
        @(posedge clock_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clock_i);
        rd_i <= 1'b0;
        @(posedge clock_i);
        v = rdata_o;
    endtask : reg_read
    // aligns to a fresh gate rise, then counts on cycles and the whole period
    task automatic measure();
        n = 0;
        while (gate_o !== 1'b0 && n < 9000)
        begin
            @(posedge clock_i);
            n++;
        end
        while (gate_o !== 1'b1 && n < 9000)
        begin
            @(posedge clock_i);
            n++;
        end
        on_c = 0;
        per_c = 0;
        while (gate_o === 1'b1 && per_c < 5000)
        begin
            @(posedge clock_i);
            on_c++;
            per_c++;
        end
        while (gate_o !== 1'b1 && per_c < 5000)
        begin
            @(posedge clock_i);
            per_c++;
        end
        check("pwm_period", per_c, 4096);
    endtask : measure
    task automatic on_near(input int exp, input int tol);
        check("on_time", (on_c >= exp - tol) && (on_c <= exp + tol), 1);
    endtask : on_near
    initial
    begin
        {arst_n_i, power_req_i, phase_low_i, phase_present_i, remote_lost_i, remote_low_i} = '0;
        {overvolt_i, undervolt_i, load_dump_i, rate_slow_i, wr_i, rd_i} = '0;
        addr_i = 8'h00;
        wdata_i = 16'h0000;
        level = 12'h000;
        bad_count = 0;
        comparisons = 0;
        repeat (2) @(posedge clock_i);
        check("reset_outs", {gate_o, lamp_o, standby_o, sense_sel_o, lrc_active_o, ramp_o},
            {6'b001000, 12'hfff});
        check("reset_rdata", rdata_o, 16'h0000);
        repeat (2) @(posedge clock_i);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        reg_read(8'h08, d);
        check("count_preset", d, 16'h004a);
        reg_read(8'h00, d);
        check("ctrl_reset", d, 16'h0000);
        // a request shorter than the power-up delay must start nothing
        phase_low_i <= 1'b1;
        phase_present_i <= 1'b1;
        power_req_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        power_req_i <= 1'b0;
        repeat (20) @(posedge clock_i);
        check("standby_glitch", standby_o, 1'b1);
        power_req_i <= 1'b1;
        n = 0;
        while (standby_o !== 1'b0 && n < 40)
        begin
            @(posedge clock_i);
            n++;
        end
        check("powerup_delay", (n >= 8) && (n <= 16), 1);
        // slow rate is picked up only at the first divider boundary, so the first step still comes after 12
        rate_slow_i <= 1'b1;
        measure();
        on_near(16'h4a * 16, 4);
        check("lrc_on", lrc_active_o, 1'b1);
        reg_read(8'h04, d);
        check("status", d & 16'hfffd, 16'h103c);
        // comparator never ends a period, so the paced count must climb
        repeat (12 * 4096) @(posedge clock_i);
        reg_read(8'h08, d);
        check("count_rises", d > 16'h004a, 1);
        phase_low_i <= 1'b0;
        level <= 12'h800;
        measure();
        check("lrc_off", lrc_active_o, 1'b0);
        on_near(2048, 10);
        phase_present_i <= 1'b0;
        level <= 12'he00;
        measure();
        on_near(512, 10);
        check("lamp_norot", lamp_o, 1'b1);
        level <= 12'h000;
        measure();
        on_near(16'h4a * 16, 4);
        phase_present_i <= 1'b1;
        overvolt_i <= 1'b1;
        measure();
        on_near(16'h0c * 16, 4);
        check("lamp_ov", lamp_o, 1'b1);
        overvolt_i <= 1'b0;
        undervolt_i <= 1'b1;
        repeat (6) @(posedge clock_i);
        check("lamp_uv_hi", lamp_o, 1'b1);
        phase_low_i <= 1'b1;
        repeat (6) @(posedge clock_i);
        check("lamp_uv_lo", lamp_o, 1'b0);
        {undervolt_i, phase_low_i, remote_lost_i} <= 3'b001;
        repeat (6) @(posedge clock_i);
        check("sense_lost", sense_sel_o, 2'b01);
        {remote_lost_i, remote_low_i} <= 2'b01;
        repeat (6) @(posedge clock_i);
        check("sense_attn", sense_sel_o, 2'b10);
        remote_low_i <= 1'b0;
        repeat (6) @(posedge clock_i);
        check("sense_remote", sense_sel_o, 2'b00);
        reg_write(8'h00, 16'h0001);
        reg_read(8'h00, d);
        check("ctrl_rw", d, 16'h0001);
        check("lamp_test", lamp_o, 1'b1);
        load_dump_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        seen_on = 1'b0;
        repeat (4200)
        begin
            @(posedge clock_i);
            seen_on = seen_on | gate_o | lamp_o;
        end
        check("dump_off", seen_on, 1'b0);
        load_dump_i <= 1'b0;
        reg_write(8'h00, 16'h0000);
        reg_write(8'h10, 16'hffff);
        reg_read(8'h10, d);
        check("unmapped", d, 16'h0000);
        reg_read(8'h00, d);
        check("ctrl_kept", d, 16'h0000);
        power_req_i <= 1'b0;
        repeat (8) @(posedge clock_i);
        check("standby_back", {standby_o, gate_o}, 2'b10);
        print_verdict();
    end
    initial
    begin
        repeat (110000) @(posedge clock_i);
        bad_count++;
        print_verdict();
    end
endmodule : alternator_field_pwm_lrc_test
